// [core/oaxe_map.vh]
// Opcode fields and encodings for the OR and move instruction executer
`ifndef OAXE_MAP_VH
`define OAXE_MAP_VH
`define OAXE_OP_LIT_HI      11
`define OAXE_OP_LIT_LO      8
`define OAXE_OP_LIT_OR      4'hd
`define OAXE_OP_REG_HI      11
`define OAXE_OP_REG_LO      6
`define OAXE_OP_OR_WF       6'h04
`define OAXE_OP_MOVE_F      6'h08
`define OAXE_DEST_BIT       5
`define OAXE_ADDR_HI        4
`define OAXE_ADDR_LO        0
`define OAXE_W_RESET        8'h00
`define OAXE_Z_RESET        1'b0
`define OAXE_WDATA_RESET    8'h00
`define OAXE_STATUS_RESET   8'h00
`define OAXE_ADDR_RESET     5'h00
`define OAXE_STATUS_Z_BIT   2
`endif

// [core/oaxe_decode.v]
// Instruction word decoder for the OR and move instructions
`timescale 1ns/10ps
`include "oaxe_map.vh"
module oaxe_decode (
    input  wire [11:0] instr_in,
    output wire        is_lit_or_out,
    output wire        is_or_wf_out,
    output wire        is_move_f_out,
    output wire        dest_file_out,
    output wire [4:0]  addr_out,
    output wire [7:0]  literal_out
);
    assign is_lit_or_out = instr_in[`OAXE_OP_LIT_HI:`OAXE_OP_LIT_LO] == `OAXE_OP_LIT_OR;
    assign is_or_wf_out  = instr_in[`OAXE_OP_REG_HI:`OAXE_OP_REG_LO] == `OAXE_OP_OR_WF;
    assign is_move_f_out = instr_in[`OAXE_OP_REG_HI:`OAXE_OP_REG_LO] == `OAXE_OP_MOVE_F;
    assign dest_file_out = instr_in[`OAXE_DEST_BIT];
    assign addr_out      = instr_in[`OAXE_ADDR_HI:`OAXE_ADDR_LO];
    assign literal_out   = instr_in[7:0];
endmodule

// [core/oaxe_exec.v]
// Single-cycle execute stage for literal OR, register OR and register move
`timescale 1ns/10ps
`include "oaxe_map.vh"
module oaxe_exec (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire        instr_valid_in,
    input  wire [11:0] instr_in,
    input  wire [7:0]  file_rdata_in,
    input  wire [7:0]  status_in,
    output reg  [4:0]  file_addr_out,
    output wire [7:0]  file_wdata_out,
    output wire        file_we_out,
    output wire [7:0]  status_wdata_out,
    output wire        status_we_out,
    output wire [7:0]  work_out,
    output wire        zero_out,
    output wire        done_out
);
    // One-hot operation select
    localparam [3:0] OP_NONE   = 4'h1;
    localparam [3:0] OP_LIT_OR = 4'h2;
    localparam [3:0] OP_OR_WF  = 4'h4;
    localparam [3:0] OP_MOVE_F = 4'h8;

    wire       is_lit_or;
    wire       is_or_wf;
    wire       is_move_f;
    wire       dest_file;
    wire [4:0] addr;
    wire [7:0] literal;

    reg  [3:0] op_sel;
    reg  [7:0] file_opnd;
    reg        fwd_hit;
    reg  [7:0] result;
    reg        hit;
    reg        to_file;

    reg  [7:0] work_ff;
    reg        zero_ff;
    reg  [7:0] file_wdata_ff;
    reg        file_we_ff;
    reg  [4:0] wr_addr_ff;
    reg  [7:0] status_wdata_ff;
    reg        status_we_ff;
    reg        done_ff;

    reg  [7:0] nxt_work;
    reg        nxt_zero;
    reg  [7:0] nxt_file_wdata;
    reg        nxt_file_we;
    reg  [4:0] nxt_wr_addr;
    reg  [7:0] nxt_status_wdata;
    reg        nxt_status_we;
    reg        nxt_done;

    oaxe_decode u_dec (
        .instr_in      (instr_in),
        .is_lit_or_out (is_lit_or),
        .is_or_wf_out  (is_or_wf),
        .is_move_f_out (is_move_f),
        .dest_file_out (dest_file),
        .addr_out      (addr),
        .literal_out   (literal)
    );

    // Zero test of an 8-bit result
    function oaxe_is_zero;
        input [7:0] res;
        begin
            oaxe_is_zero = (res == 8'h00);
        end
    endfunction

    // Status word with only the zero bit replaced
    function [7:0] oaxe_set_z;
        input [7:0] stat;
        input [7:0] res;
        begin
            oaxe_set_z = stat;
            oaxe_set_z[`OAXE_STATUS_Z_BIT] = oaxe_is_zero(res);
        end
    endfunction

    // One-hot operation from the decoded opcode flags
    function [3:0] oaxe_op_of;
        input valid;
        input lit_or;
        input or_wf;
        input move_f;
        begin
            if (!valid) begin
                oaxe_op_of = OP_NONE;
            end else if (lit_or) begin
                oaxe_op_of = OP_LIT_OR;
            end else if (or_wf) begin
                oaxe_op_of = OP_OR_WF;
            end else if (move_f) begin
                oaxe_op_of = OP_MOVE_F;
            end else begin
                oaxe_op_of = OP_NONE;
            end
        end
    endfunction

    // Address goes out combinationally so the file read is in the same cycle
    always @* begin
        file_addr_out = addr;
    end

    // A write still pending to the same file register is forwarded,
    // since the far side commits it only at the next edge
    always @* begin
        fwd_hit   = file_we_ff && (wr_addr_ff == addr);
        file_opnd = file_rdata_in;
        if (fwd_hit) begin
            file_opnd = file_wdata_ff;
        end
    end

    always @* begin
        op_sel  = oaxe_op_of(instr_valid_in, is_lit_or, is_or_wf, is_move_f);
        result  = 8'h00;
        hit     = 1'b0;
        to_file = 1'b0;
        case (op_sel)
            OP_LIT_OR: begin
                result = work_ff | literal;
                hit    = 1'b1;
            end
            OP_OR_WF: begin
                result  = work_ff | file_opnd;
                hit     = 1'b1;
                to_file = dest_file;
            end
            OP_MOVE_F: begin
                result  = file_opnd;
                hit     = 1'b1;
                to_file = dest_file;
            end
            OP_NONE: begin
                result  = 8'h00;
                hit     = 1'b0;
                to_file = 1'b0;
            end
            default: begin
                result  = 8'h00;
                hit     = 1'b0;
                to_file = 1'b0;
            end
        endcase
    end

    always @* begin
        nxt_work         = work_ff;
        nxt_zero         = zero_ff;
        nxt_file_wdata   = result;
        nxt_file_we      = 1'b0;
        nxt_wr_addr      = addr;
        nxt_status_wdata = status_wdata_ff;
        nxt_status_we    = 1'b0;
        nxt_done         = 1'b0;
        if (hit) begin
            if (to_file) begin
                nxt_file_we = 1'b1;
            end else begin
                nxt_work = result;
            end
            nxt_zero         = oaxe_is_zero(result);
            nxt_status_wdata = oaxe_set_z(status_in, result);
            nxt_status_we    = 1'b1;
            nxt_done         = 1'b1;
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            work_ff <= `OAXE_W_RESET;
            zero_ff <= `OAXE_Z_RESET;
        end else begin
            work_ff <= nxt_work;
            zero_ff <= nxt_zero;
        end
    end

    // Write-back data, strobe and the address they belong to
    always @(posedge clk_in) begin
        if (rst_in) begin
            file_wdata_ff <= `OAXE_WDATA_RESET;
            file_we_ff    <= 1'b0;
            wr_addr_ff    <= `OAXE_ADDR_RESET;
        end else begin
            file_wdata_ff <= nxt_file_wdata;
            file_we_ff    <= nxt_file_we;
            wr_addr_ff    <= nxt_wr_addr;
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            status_wdata_ff <= `OAXE_STATUS_RESET;
            status_we_ff    <= 1'b0;
            done_ff         <= 1'b0;
        end else begin
            status_wdata_ff <= nxt_status_wdata;
            status_we_ff    <= nxt_status_we;
            done_ff         <= nxt_done;
        end
    end

    assign work_out         = work_ff;
    assign zero_out         = zero_ff;
    assign file_wdata_out   = file_wdata_ff;
    assign file_we_out      = file_we_ff;
    assign status_wdata_out = status_wdata_ff;
    assign status_we_out    = status_we_ff;
    assign done_out         = done_ff;
endmodule

// [dv/oaxe_exec_asserts.sv]
// Port checker for the OR and move executer
`timescale 1ns/10ps
module oaxe_exec_chk (
    input wire        clk_in,
    input wire        rst_in,
    input wire        instr_valid_in,
    input wire [11:0] instr_in,
    input wire [7:0]  file_rdata_in,
    input wire [7:0]  status_in,
    input wire [4:0]  file_addr_out,
    input wire [7:0]  file_wdata_out,
    input wire        file_we_out,
    input wire [7:0]  status_wdata_out,
    input wire        status_we_out,
    input wire [7:0]  work_out,
    input wire        zero_out,
    input wire        done_out
);
    wire       lit = instr_valid_in && instr_in[11:8] == 4'hd;
    wire       orf = instr_valid_in && instr_in[11:6] == 6'h04;
    wire       mvf = instr_valid_in && instr_in[11:6] == 6'h08;
    wire       any = lit || orf || mvf;
    wire       d   = instr_in[5];
    wire [7:0] ol  = work_out | instr_in[7:0];
    reg  [4:0] wa_ff = 5'h00;
    // A pending write to the read address is the register's true value
    wire       fw  = file_we_out && wa_ff == file_addr_out;
    wire [7:0] fr  = fw ? file_wdata_out : file_rdata_in;
    wire [7:0] ow  = work_out | fr;
    always @(posedge clk_in) begin
        wa_ff <= file_addr_out;
    end
    wire [7:0] res = file_we_out ? file_wdata_out : work_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    AST_LIT: assert property (lit |=> work_out == $past(ol)) else $error("lit");
    AST_DONE: assert property (any |=> done_out && status_we_out
        && (status_wdata_out & 8'hfb) == ($past(status_in) & 8'hfb)) else $error("done");
    AST_IDLE: assert property (!any |=> !done_out && !file_we_out && $stable(work_out))
        else $error("idle");
    AST_ORW: assert property (orf && !d |=> work_out == $past(ow) && !file_we_out) else $error("orw");
    AST_ORF: assert property (orf && d |=> file_we_out && file_wdata_out == $past(ow)) else $error("orf");
    AST_MVW: assert property (mvf && !d |=> work_out == $past(fr)) else $error("mvw");
    AST_MVF: assert property (mvf && d |=> file_we_out && $stable(work_out)
        && file_wdata_out == $past(fr)) else $error("mvf");
    AST_Z: assert property (done_out |-> zero_out == (res == 8'h00)
        && status_wdata_out[2] == zero_out) else $error("z");
endmodule
bind oaxe_exec oaxe_exec_chk CHK (.clk_in, .rst_in, .instr_valid_in, .instr_in, .file_rdata_in,
    .status_in, .file_addr_out, .file_wdata_out, .file_we_out, .status_wdata_out,
    .status_we_out, .work_out, .zero_out, .done_out);

// [dv/oaxe_fmem.sv]
// File register and status partner model
`timescale 1ns/10ps
module oaxe_fmem (
    input  wire       clk_in, we_in, st_we_in,
    input  wire [4:0] addr_in,
    input  wire [7:0] wdata_in, st_wdata_in,
    output wire [7:0] rdata_out,
    output reg  [7:0] status_out = 8'hfb
);
    reg [7:0] mem [0:31];
    reg [4:0] addr_ff;
    assign rdata_out = mem[addr_in];
    always @(posedge clk_in) begin
        addr_ff <= addr_in;
        if (we_in) mem[addr_ff] <= wdata_in;
        if (st_we_in) status_out <= st_wdata_in;
    end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the OR and move executer
`timescale 1ns/10ps
module testbench;
    reg         clk_in = 1'b0, rst_in = 1'b1, vld = 1'b0;
    reg  [11:0] ins = 12'h000;
    wire [7:0]  rd, st, fwd, swd, w;
    wire [4:0]  fa;
    wire        fwe, swe, z, dn;
    integer     fails = 0, compares = 0;
    always #2.5 clk_in = ~clk_in;
    oaxe_exec DUT (.clk_in, .rst_in, .instr_valid_in(vld), .instr_in(ins), .file_rdata_in(rd),
        .status_in(st), .file_addr_out(fa), .file_wdata_out(fwd), .file_we_out(fwe),
        .status_wdata_out(swd), .status_we_out(swe), .work_out(w), .zero_out(z), .done_out(dn));
    oaxe_fmem FM (.clk_in, .we_in(fwe), .st_we_in(swe), .addr_in(fa), .wdata_in(fwd),
        .st_wdata_in(swd), .rdata_out(rd), .status_out(st));
    task check(input [15:0] nm, input [9:0] seen, input [9:0] exp); begin
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    end endtask
    task ex(input [11:0] i, input [9:0] e); begin
        ins = i;
        vld = 1'b1;
        @(posedge clk_in);
        #1 check("zw", {dn, z, w}, e);
    end endtask
    task t_lit; begin
        ex(12'hd9a, 10'h29a);
        ex(12'hd35, 10'h2bf);
        check("st", swd, 8'hfb);
        $display("lit done");
    end endtask
    task t_reg; begin
        FM.mem[1] = 8'h91;
        FM.mem[19] = 8'h13;
        ex(12'h201, 10'h291);
        ex(12'h113, 10'h293);
        ex(12'h133, 10'h293);
        check("fw", {fwe, fwd}, 10'h193);
        $display("reg done");
    end endtask
    task t_zero; begin
        FM.mem[0] = 8'h00;
        ex(12'h220, 10'h393);
        check("st", swd, 8'hff);
        ex(12'h200, 10'h300);
        ex(12'h0a0, 10'h100);
        $display("zero done");
    end endtask
    task t_fwd; begin
        FM.mem[5] = 8'h41;
        ex(12'hd3c, 10'h23c);
        check("sw", {swe, swd}, 10'h1fb);
        ex(12'h125, 10'h23c);
        check("fw", {fwe, fwd}, 10'h17d);
        ex(12'h205, 10'h27d);
        check("fm", FM.mem[5], 10'h07d);
        check("fa", fa, 10'h005);
        $display("fwd done");
    end endtask
    task t_idle; begin
        vld = 1'b0;
        ins = 12'hdff;
        @(posedge clk_in);
        #1 check("zw", {dn, z, w}, 10'h07d);
        check("we", {swe, fwe}, 10'h000);
        FM.status_out = 8'h5c;
        ex(12'hd00, 10'h27d);
        check("sw", {swe, swd}, 10'h158);
        $display("idle done");
    end endtask
    task t_rst; begin
        ex(12'h220, 10'h37d);
        rst_in = 1'b1;
        ins = 12'hdff;
        repeat (2) @(posedge clk_in);
        #1 check("zw", {dn, z, w}, 10'h000);
        check("we", {swe, fwe}, 10'h000);
        rst_in = 1'b0;
        ex(12'hd00, 10'h300);
        $display("rst done");
    end endtask
    task final_report; begin
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    end endtask
    initial begin
        repeat (2) @(posedge clk_in);
        #1 rst_in = 1'b0;
        t_lit;
        t_reg;
        t_zero;
        t_fwd;
        t_idle;
        t_rst;
        final_report;
    end
    initial begin
        #20000;
        fails = fails + 1;
        final_report;
    end
endmodule
